// *** core/pipe_desc_pkg.sv ***
// Shared constants and types for the host pipe descriptor block
package pipe_desc_pkg;

  // ----------------------------------------------------------------
  // Bus and register map
  // ----------------------------------------------------------------
  localparam int ADDR_W = 8;
  localparam int DATA_W = 32;
  // Register indexes; byte address is four times the index
  localparam int IDX_PACKET_SIZE = 'h04;
  localparam int IDX_EXT_TOKEN = 'h08;
  localparam int IDX_BANK_STATUS = 'h0a;
  localparam int IDX_PIPE_CONTROL = 'h0c;
  localparam int IDX_PIPE_STATUS = 'h0e;
  localparam int IDX_PIPE_CONFIG = 'h10;
  localparam logic [ADDR_W-1:0] ADDR_PACKET_SIZE = ADDR_W'(IDX_PACKET_SIZE * 4);
  localparam logic [ADDR_W-1:0] ADDR_EXT_TOKEN = ADDR_W'(IDX_EXT_TOKEN * 4);
  localparam logic [ADDR_W-1:0] ADDR_BANK_STATUS = ADDR_W'(IDX_BANK_STATUS * 4);
  localparam logic [ADDR_W-1:0] ADDR_PIPE_CONTROL = ADDR_W'(IDX_PIPE_CONTROL * 4);
  localparam logic [ADDR_W-1:0] ADDR_PIPE_STATUS = ADDR_W'(IDX_PIPE_STATUS * 4);
  localparam logic [ADDR_W-1:0] ADDR_PIPE_CONFIG = ADDR_W'(IDX_PIPE_CONFIG * 4);
  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;

  // ----------------------------------------------------------------
  // Field layout
  // ----------------------------------------------------------------
  localparam int MPS_LSB = 14;
  localparam int MPS_W = 14;
  localparam int BC_LSB = 8;
  localparam int BC_W = 6;
  localparam int SIZE_LSB = 28;
  localparam int SIZE_W = 3;
  localparam int ZLP_BIT = 31;
  localparam int SUB_LSB = 0;
  localparam int SUB_W = 4;
  localparam int VAR_LSB = 4;
  localparam int VAR_W = 11;
  localparam int DA_LSB = 0;
  localparam int DA_W = 7;
  localparam int EP_LSB = 8;
  localparam int EP_W = 4;
  localparam int LIM_LSB = 12;
  localparam int LIM_W = 4;
  localparam int TALLY_LSB = 5;
  localparam int TALLY_W = 3;
  localparam int CRC16_BIT = 4;
  localparam int TOUT_BIT = 3;
  localparam int PID_BIT = 2;
  localparam int DPID_BIT = 1;
  localparam int TGL_BIT = 0;
  localparam int FLOW_BIT = 1;
  localparam int ISOCRC_BIT = 0;
  localparam int CFG_IN_BIT = 0;
  localparam int CFG_ISO_BIT = 1;
  localparam int CFG_THAW_BIT = 2;
  localparam int CFG_FROZEN_BIT = 8;
  localparam int CNT_W = 10;
  localparam int PKT_W = 11;

  // ----------------------------------------------------------------
  // Reset values and packet sizing
  // ----------------------------------------------------------------
  localparam logic [31:0] PACKET_SIZE_RST = 32'h0000_0000;
  localparam logic [15:0] EXT_TOKEN_RST = 16'h0000;
  localparam logic [15:0] PIPE_CONTROL_RST = 16'h0000;
  localparam logic [1:0] BANK_STATUS_RST = 2'h0;
  localparam logic [PKT_W-1:0] BASE_PKT_BYTES = 11'h008;
  localparam logic [PKT_W-1:0] FS_TOP_PKT_BYTES = 11'h3ff;
  localparam logic [SIZE_W-1:0] SIZE_TOP_CODE = 3'h7;
  localparam logic [15:0] EXT_WR_MASK = 16'h7fff;
  localparam logic [15:0] CTRL_WR_MASK = 16'hff7f;

  typedef enum logic [2:0] {
    SEL_NONE = 3'b000,
    SEL_PKT = 3'b001,
    SEL_EXT = 3'b010,
    SEL_BANK = 3'b011,
    SEL_CTRL = 3'b100,
    SEL_STAT = 3'b101,
    SEL_CFG = 3'b110
  } reg_sel_e;

  // Outcome of one USB transaction, reported by the protocol engine
  typedef struct packed {
    logic nak;
    logic iso_overrun;
    logic iso_underflow;
    logic crc16_err;
    logic timeout;
    logic pid_err;
    logic data_pid_err;
    logic toggle_err;
    logic data_ok;
    logic [CNT_W-1:0] byte_cnt;
  } txn_result_s;

  // Fields the protocol engine puts on the wire
  typedef struct packed {
    logic [SUB_W-1:0] ext_token_subtype;
    logic [VAR_W-1:0] ext_payload;
    logic [EP_W-1:0] target_endpoint;
    logic [DA_W-1:0] target_device_addr;
  } token_s;

endpackage

// *** core/pipe_err_tracker.sv ***
// Pipe error flags, error tally and automatic freeze
`timescale 1ns/1ns
`default_nettype none
module pipe_err_tracker
  import pipe_desc_pkg::*;
(
  input wire logic sys_clk,
  input wire logic rst_n,
  input wire logic txn_valid,
  input wire txn_result_s txn,
  input wire logic [LIM_W-1:0] error_limit,
  input wire logic sw_wr,
  input wire logic [2:0] sw_flags,
  input wire logic thaw,
  output logic [7:0] status_q,
  output logic frozen_q
);

  logic [7:0] status_d;
  logic frozen_d;
  logic [TALLY_W-1:0] tally_q;
  logic [TALLY_W-1:0] tally_d;
  logic err_any;

  always_comb begin
    err_any = txn_valid & (txn.crc16_err | txn.timeout | txn.pid_err |
                           txn.data_pid_err | txn.toggle_err);
    status_d = status_q;
    tally_d = tally_q;
    frozen_d = frozen_q;
    // Software write restarts the record; hardware sets below still win
    if (sw_wr) begin
      status_d = {5'h00, sw_flags};
      tally_d = '0;
    end
    if (thaw) begin
      frozen_d = 1'b0;
    end
    if (txn_valid) begin
      status_d[CRC16_BIT] = status_d[CRC16_BIT] | txn.crc16_err;
      status_d[TOUT_BIT] = status_d[TOUT_BIT] | txn.timeout;
      status_d[PID_BIT] = status_d[PID_BIT] | txn.pid_err;
      status_d[DPID_BIT] = status_d[DPID_BIT] | txn.data_pid_err;
      status_d[TGL_BIT] = status_d[TGL_BIT] | txn.toggle_err;
    end
    if (err_any && (tally_d != '1)) begin
      tally_d = tally_d + TALLY_W'(1);
    end
    if (err_any && ({1'b0, tally_d} >= error_limit)) begin
      frozen_d = 1'b1;
    end
    status_d[TALLY_LSB +: TALLY_W] = tally_d;
  end

  always_ff @(posedge sys_clk) begin
    if (!rst_n) begin
      status_q <= 8'h00;
      tally_q <= '0;
      frozen_q <= 1'b0;
    end else begin
      status_q <= status_d;
      tally_q <= tally_d;
      frozen_q <= frozen_d;
    end
  end

  // ----------------------------------------------------------------
  // Checks
  // ----------------------------------------------------------------
  property p_tout_set;
    @(posedge sys_clk) disable iff (!rst_n)
      txn_valid && txn.timeout |=> status_q[TOUT_BIT];
  endproperty
  a_tout_set: assert property (p_tout_set) else $error("timeout flag not set");

  property p_crc16_set;
    @(posedge sys_clk) disable iff (!rst_n)
      txn_valid && txn.crc16_err |=> status_q[CRC16_BIT] && status_q[TALLY_LSB +: TALLY_W] != 0;
  endproperty
  a_crc16_set: assert property (p_crc16_set) else $error("crc16 flag or tally wrong");

  property p_tally_inc;
    @(posedge sys_clk) disable iff (!rst_n)
      err_any && !sw_wr && tally_q != '1 |=> tally_q == $past(tally_q) + 3'h1;
  endproperty
  a_tally_inc: assert property (p_tally_inc) else $error("tally did not step");

  property p_freeze;
    @(posedge sys_clk) disable iff (!rst_n)
      err_any && !sw_wr && ({1'b0, tally_q} + 4'h1 >= error_limit) && tally_q != '1
      |=> frozen_q;
  endproperty
  a_freeze: assert property (p_freeze) else $error("pipe not frozen at limit");

  property p_pid_set;
    @(posedge sys_clk) disable iff (!rst_n)
      txn_valid && txn.pid_err && txn.toggle_err |=> status_q[PID_BIT] && status_q[TGL_BIT];
  endproperty
  a_pid_set: assert property (p_pid_set) else $error("pid or toggle flag lost");

  c_frozen: cover property (@(posedge sys_clk) disable iff (!rst_n) $rose(frozen_q));

endmodule
`default_nettype wire

// *** core/pipe_desc_top.sv ***
// Host pipe descriptor registers with AXI4-Lite access and status capture
//
// How it works
// - 14-bit multi-packet size at bits 27:14
// - IN pipe accumulates received bytes there
// - OUT pipe size is whole transfer total
// - Byte count bits 13:8, last OUT/next IN
// - Extended token sends payload bits 14:4
// - Extended token subtype from bits 3:0
// - Flow fault on NAK, overrun, underflow
// - Iso IN CRC error sets bank bit 0
// - Freeze pipe when 3-bit error tally reaches limit
// - Tokens use endpoint 11:8, address 6:0
// - Error tally at status 7:5, cleared by status write
// - CRC16 mismatch on IN sets bit 4
// - Timeout sets status bit 3
// - Bad PID sets status bit 2
// - Data PID error sets status bit 1
// - Toggle mismatch sets status bit 0
// - Size code selects 8 to 1023 bytes
//
// Added by the designer: the AXI4-Lite register port.
`timescale 1ns/1ns
`default_nettype none
module pipe_desc_top
  import pipe_desc_pkg::*;
(
  input wire logic sys_clk,
  input wire logic rst_n,
  input wire logic [ADDR_W-1:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [DATA_W-1:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic [ADDR_W-1:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  output logic [DATA_W-1:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready,
  input wire logic txn_valid,
  input wire txn_result_s txn,
  output token_s token,
  output logic [PKT_W-1:0] max_pkt_bytes,
  output logic [MPS_W-1:0] xfer_size,
  output logic [BC_W-1:0] byte_count,
  output logic auto_zlp,
  output logic pipe_is_in,
  output logic pipe_is_iso,
  output logic pipe_frozen
);

  // ----------------------------------------------------------------
  // Helpers
  // ----------------------------------------------------------------
  function automatic reg_sel_e decode(input logic [ADDR_W-1:0] addr);
    logic [ADDR_W-1:0] a;
    a = {addr[ADDR_W-1:2], 2'b00};
    if (a == ADDR_PACKET_SIZE) return SEL_PKT;
    if (a == ADDR_EXT_TOKEN) return SEL_EXT;
    if (a == ADDR_BANK_STATUS) return SEL_BANK;
    if (a == ADDR_PIPE_CONTROL) return SEL_CTRL;
    if (a == ADDR_PIPE_STATUS) return SEL_STAT;
    if (a == ADDR_PIPE_CONFIG) return SEL_CFG;
    return SEL_NONE;
  endfunction

  function automatic logic [31:0] merge(input logic [31:0] old, input logic [31:0] data,
                                        input logic [3:0] strb);
    logic [31:0] r;
    r = old;
    for (int i = 0; i < 4; i++) begin
      if (strb[i]) r[i*8 +: 8] = data[i*8 +: 8];
    end
    return r;
  endfunction

  // Code 7 is 1023 bytes because this port only runs full speed
  function automatic logic [PKT_W-1:0] pkt_bytes(input logic [SIZE_W-1:0] code);
    if (code == SIZE_TOP_CODE) return FS_TOP_PKT_BYTES;
    return BASE_PKT_BYTES << code;
  endfunction

  // ----------------------------------------------------------------
  // Register state
  // ----------------------------------------------------------------
  logic [31:0] pkt_q, pkt_d;
  logic [15:0] ext_q, ext_d;
  logic [1:0] bank_q, bank_d;
  logic [15:0] ctrl_q, ctrl_d;
  logic cfg_in_q, cfg_in_d;
  logic cfg_iso_q, cfg_iso_d;
  logic [7:0] pipe_status;
  logic frozen;
  logic stat_wr, thaw;
  logic [31:0] wr_word;

  // ----------------------------------------------------------------
  // AXI4-Lite channel state
  // ----------------------------------------------------------------
  logic aw_held_q, aw_held_d;
  logic [ADDR_W-1:0] aw_addr_q, aw_addr_d;
  logic w_held_q, w_held_d;
  logic [DATA_W-1:0] w_data_q, w_data_d;
  logic [3:0] w_strb_q, w_strb_d;
  logic bvalid_d, arready_d, rvalid_d, awready_d, wready_d;
  logic [1:0] bresp_d, rresp_d;
  logic [DATA_W-1:0] rdata_d;
  logic wr_fire;
  reg_sel_e wsel, rsel;

  always_comb begin
    aw_held_d = aw_held_q;
    aw_addr_d = aw_addr_q;
    w_held_d = w_held_q;
    w_data_d = w_data_q;
    w_strb_d = w_strb_q;
    bvalid_d = s_axi_bvalid;
    bresp_d = s_axi_bresp;
    rvalid_d = s_axi_rvalid;
    rresp_d = s_axi_rresp;
    rdata_d = s_axi_rdata;
    if (s_axi_awvalid && s_axi_awready) begin
      aw_held_d = 1'b1;
      aw_addr_d = s_axi_awaddr;
    end
    if (s_axi_wvalid && s_axi_wready) begin
      w_held_d = 1'b1;
      w_data_d = s_axi_wdata;
      w_strb_d = s_axi_wstrb;
    end
    if (s_axi_bvalid && s_axi_bready) begin
      bvalid_d = 1'b0;
    end
    // Write lands once both halves are held and no answer is pending
    wr_fire = aw_held_q && w_held_q && !s_axi_bvalid;
    wsel = decode(aw_addr_q);
    if (wr_fire) begin
      aw_held_d = 1'b0;
      w_held_d = 1'b0;
      bvalid_d = 1'b1;
      bresp_d = (wsel == SEL_NONE) ? RESP_SLVERR : RESP_OKAY;
    end
    if (s_axi_rvalid && s_axi_rready) begin
      rvalid_d = 1'b0;
    end
    rsel = decode(s_axi_araddr);
    if (s_axi_arvalid && s_axi_arready) begin
      rvalid_d = 1'b1;
      rresp_d = (rsel == SEL_NONE) ? RESP_SLVERR : RESP_OKAY;
      unique case (rsel)
        SEL_PKT: rdata_d = pkt_q;
        SEL_EXT: rdata_d = {16'h0000, ext_q};
        SEL_BANK: rdata_d = {30'h0000_0000, bank_q};
        SEL_CTRL: rdata_d = {16'h0000, ctrl_q};
        SEL_STAT: rdata_d = {24'h00_0000, pipe_status};
        SEL_CFG: rdata_d = 32'((32'(frozen) << CFG_FROZEN_BIT)
                               | (32'(cfg_iso_q) << CFG_ISO_BIT)
                               | (32'(cfg_in_q) << CFG_IN_BIT));
        SEL_NONE: rdata_d = 32'h0000_0000;
      endcase
    end
    // Ready is withheld while a channel's item is parked or answered
    awready_d = !aw_held_d && !bvalid_d;
    wready_d = !w_held_d && !bvalid_d;
    arready_d = !rvalid_d;
  end

  always_ff @(posedge sys_clk) begin
    if (!rst_n) begin
      aw_held_q <= 1'b0;
      aw_addr_q <= '0;
      w_held_q <= 1'b0;
      w_data_q <= '0;
      w_strb_q <= '0;
      s_axi_awready <= 1'b0;
      s_axi_wready <= 1'b0;
      s_axi_bvalid <= 1'b0;
      s_axi_bresp <= RESP_OKAY;
      s_axi_arready <= 1'b0;
      s_axi_rvalid <= 1'b0;
      s_axi_rresp <= RESP_OKAY;
      s_axi_rdata <= '0;
    end else begin
      aw_held_q <= aw_held_d;
      aw_addr_q <= aw_addr_d;
      w_held_q <= w_held_d;
      w_data_q <= w_data_d;
      w_strb_q <= w_strb_d;
      s_axi_awready <= awready_d;
      s_axi_wready <= wready_d;
      s_axi_bvalid <= bvalid_d;
      s_axi_bresp <= bresp_d;
      s_axi_arready <= arready_d;
      s_axi_rvalid <= rvalid_d;
      s_axi_rresp <= rresp_d;
      s_axi_rdata <= rdata_d;
    end
  end

  // ----------------------------------------------------------------
  // Descriptor registers and hardware write-back
  // ----------------------------------------------------------------
  always_comb begin
    pkt_d = pkt_q;
    ext_d = ext_q;
    bank_d = bank_q;
    ctrl_d = ctrl_q;
    cfg_in_d = cfg_in_q;
    cfg_iso_d = cfg_iso_q;
    stat_wr = 1'b0;
    thaw = 1'b0;
    wr_word = 32'h0000_0000;
    if (wr_fire) begin
      unique case (wsel)
        SEL_PKT: begin
          wr_word = merge(pkt_q, w_data_q, w_strb_q);
          pkt_d = {wr_word[31:8], 8'h00};
        end
        SEL_EXT: begin
          wr_word = merge({16'h0000, ext_q}, w_data_q, w_strb_q);
          ext_d = wr_word[15:0] & EXT_WR_MASK;
        end
        SEL_BANK: begin
          wr_word = merge({30'h0000_0000, bank_q}, w_data_q, w_strb_q);
          bank_d = wr_word[1:0];
        end
        SEL_CTRL: begin
          wr_word = merge({16'h0000, ctrl_q}, w_data_q, w_strb_q);
          ctrl_d = wr_word[15:0] & CTRL_WR_MASK;
        end
        SEL_STAT: begin
          wr_word = merge({24'h00_0000, pipe_status}, w_data_q, w_strb_q);
          stat_wr = w_strb_q[0];
        end
        SEL_CFG: begin
          wr_word = merge({31'h0000_0000, 1'b0}, w_data_q, w_strb_q);
          cfg_in_d = w_strb_q[0] ? wr_word[CFG_IN_BIT] : cfg_in_q;
          cfg_iso_d = w_strb_q[0] ? wr_word[CFG_ISO_BIT] : cfg_iso_q;
          thaw = w_strb_q[0] & wr_word[CFG_THAW_BIT];
        end
        SEL_NONE: wr_word = 32'h0000_0000;
      endcase
    end
    // Hardware sets are applied after the bus write so they win
    if (txn_valid) begin
      if (txn.nak || (cfg_iso_q && cfg_in_q && txn.iso_overrun)
          || (cfg_iso_q && !cfg_in_q && txn.iso_underflow)) begin
        bank_d[FLOW_BIT] = 1'b1;
      end
      if (cfg_iso_q && cfg_in_q && txn.crc16_err) begin
        bank_d[ISOCRC_BIT] = 1'b1;
      end
      if (cfg_in_q && txn.data_ok) begin
        pkt_d[MPS_LSB +: MPS_W] = pkt_d[MPS_LSB +: MPS_W] + MPS_W'(txn.byte_cnt);
      end
      if (!cfg_in_q && txn.data_ok) begin
        pkt_d[BC_LSB +: BC_W] = txn.byte_cnt[BC_W-1:0];
      end
    end
  end

  always_ff @(posedge sys_clk) begin
    if (!rst_n) begin
      pkt_q <= PACKET_SIZE_RST;
      ext_q <= EXT_TOKEN_RST;
      bank_q <= BANK_STATUS_RST;
      ctrl_q <= PIPE_CONTROL_RST;
      cfg_in_q <= 1'b0;
      cfg_iso_q <= 1'b0;
    end else begin
      pkt_q <= pkt_d;
      ext_q <= ext_d;
      bank_q <= bank_d;
      ctrl_q <= ctrl_d;
      cfg_in_q <= cfg_in_d;
      cfg_iso_q <= cfg_iso_d;
    end
  end

  pipe_err_tracker u_err (
    .sys_clk(sys_clk),
    .rst_n(rst_n),
    .txn_valid(txn_valid),
    .txn(txn),
    .error_limit(ctrl_q[LIM_LSB +: LIM_W]),
    .sw_wr(stat_wr),
    .sw_flags(wr_word[2:0]),
    .thaw(thaw),
    .status_q(pipe_status),
    .frozen_q(frozen)
  );

  // ----------------------------------------------------------------
  // Registered view for the protocol engine
  // ----------------------------------------------------------------
  always_ff @(posedge sys_clk) begin
    if (!rst_n) begin
      token <= '0;
      max_pkt_bytes <= BASE_PKT_BYTES;
      xfer_size <= '0;
      byte_count <= '0;
      auto_zlp <= 1'b0;
      pipe_is_in <= 1'b0;
      pipe_is_iso <= 1'b0;
      pipe_frozen <= 1'b0;
    end else begin
      token.ext_token_subtype <= ext_q[SUB_LSB +: SUB_W];
      token.ext_payload <= ext_q[VAR_LSB +: VAR_W];
      token.target_endpoint <= ctrl_q[EP_LSB +: EP_W];
      token.target_device_addr <= ctrl_q[DA_LSB +: DA_W];
      max_pkt_bytes <= pkt_bytes(pkt_q[SIZE_LSB +: SIZE_W]);
      xfer_size <= pkt_q[MPS_LSB +: MPS_W];
      byte_count <= pkt_q[BC_LSB +: BC_W];
      auto_zlp <= pkt_q[ZLP_BIT];
      pipe_is_in <= cfg_in_q;
      pipe_is_iso <= cfg_iso_q;
      pipe_frozen <= frozen;
    end
  end

  // ----------------------------------------------------------------
  // Checks
  // ----------------------------------------------------------------
  property p_flow_nak;
    @(posedge sys_clk) disable iff (!rst_n)
      txn_valid && txn.nak |=> bank_q[FLOW_BIT];
  endproperty
  a_flow_nak: assert property (p_flow_nak) else $error("nak did not set flow fault");

  property p_iso_crc;
    @(posedge sys_clk) disable iff (!rst_n)
      txn_valid && txn.crc16_err && cfg_iso_q && cfg_in_q |=> bank_q[ISOCRC_BIT];
  endproperty
  a_iso_crc: assert property (p_iso_crc) else $error("iso crc flag not set");

  property p_in_total;
    @(posedge sys_clk) disable iff (!rst_n)
      txn_valid && txn.data_ok && cfg_in_q && !(wr_fire && wsel == SEL_PKT)
      |=> pkt_q[MPS_LSB +: MPS_W] ==
          $past(pkt_q[MPS_LSB +: MPS_W]) + MPS_W'($past(txn.byte_cnt));
  endproperty
  a_in_total: assert property (p_in_total) else $error("IN byte total wrong");

  property p_token_addr;
    @(posedge sys_clk) disable iff (!rst_n)
      ##1 token.target_device_addr == $past(ctrl_q[DA_LSB +: DA_W]);
  endproperty
  a_token_addr: assert property (p_token_addr) else $error("device address mismatch");

  property p_ext_fields;
    @(posedge sys_clk) disable iff (!rst_n)
      $changed(ext_q) |=> token.ext_payload == $past(ext_q[VAR_LSB +: VAR_W])
                          && token.ext_token_subtype == $past(ext_q[SUB_LSB +: SUB_W]);
  endproperty
  a_ext_fields: assert property (p_ext_fields) else $error("extended token stale");

  property p_size_64;
    @(posedge sys_clk) disable iff (!rst_n)
      pkt_q[SIZE_LSB +: SIZE_W] == 3'h3 |=> max_pkt_bytes == 11'h040;
  endproperty
  a_size_64: assert property (p_size_64) else $error("size code 3 not 64 bytes");

  property p_read_answer;
    @(posedge sys_clk) disable iff (!rst_n)
      s_axi_arvalid && s_axi_arready |=> s_axi_rvalid ##0 !s_axi_arready;
  endproperty
  a_read_answer: assert property (p_read_answer) else $error("read answer late");

  c_write: cover property (@(posedge sys_clk) disable iff (!rst_n)
    s_axi_bvalid && s_axi_bready && s_axi_bresp == RESP_OKAY);
  c_read: cover property (@(posedge sys_clk) disable iff (!rst_n) s_axi_rvalid && s_axi_rready);
  c_in_data: cover property (@(posedge sys_clk) disable iff (!rst_n)
    txn_valid && txn.data_ok && cfg_in_q);

endmodule
`default_nettype wire

// *** bench/usb_dev_model.sv ***
// Behavioural USB device that reports one transaction outcome after a delay
`timescale 1ns/1ns
`default_nettype none
module usb_dev_model
  import pipe_desc_pkg::*;
(
  input wire logic sys_clk,
  input wire logic go,
  input wire logic [3:0] lat,
  input wire txn_result_s res,
  output logic txn_valid,
  output txn_result_s txn
);
  logic [3:0] cnt_q = 4'h0;
  txn_result_s hold_q = '0;
  initial txn_valid = 1'h0;
  initial txn = '0;
  // Lines carry junk between reports so a stale value is never trusted
  always @(posedge sys_clk) begin
    txn_valid <= 1'h0;
    txn <= ~txn;
    if (go) begin
      cnt_q <= lat;
      hold_q <= res;
    end else if (cnt_q == 4'h1) begin
      txn_valid <= 1'h1;
      txn <= hold_q;
      cnt_q <= 4'h0;
    end else if (cnt_q != 4'h0) begin
      cnt_q <= cnt_q - 4'h1;
    end
  end
endmodule
`default_nettype wire

// *** bench/usb_host_pipe_descriptor_test.sv ***
// Self-checking bench for the pipe descriptor block
`timescale 1ns/1ns
`default_nettype none
`define CHK(n, x, y) begin comparisons++; if ((y) !== (x)) begin err_total++; \
  $display("BAD %s exp %h got %h", n, x, y); end end
module usb_host_pipe_descriptor_test
  import pipe_desc_pkg::*;
;
  logic sys_clk = 1'h0;
  logic rst_n = 1'h0;
  logic [7:0] s_axi_awaddr = 8'h00, s_axi_araddr = 8'h00;
  logic [31:0] s_axi_wdata = '0, s_axi_rdata, r, e;
  logic [3:0] s_axi_wstrb = 4'hf, lat = 4'h1;
  logic s_axi_awvalid = 1'h0, s_axi_wvalid = 1'h0, s_axi_bready = 1'h0;
  logic s_axi_arvalid = 1'h0, s_axi_rready = 1'h0, go = 1'h0;
  logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid, txn_valid;
  logic [1:0] s_axi_bresp, s_axi_rresp, rsp;
  txn_result_s txn, res = '0;
  token_s token;
  logic [PKT_W-1:0] max_pkt_bytes;
  logic [MPS_W-1:0] xfer_size;
  logic [BC_W-1:0] byte_count;
  logic auto_zlp, pipe_is_in, pipe_is_iso, pipe_frozen;
  int err_total = 0, comparisons = 0, cycles = 0, seed = 90, k;

  pipe_desc_top dut (.*);
  usb_dev_model dev (.*);

  always #50 sys_clk = ~sys_clk;
  always @(posedge sys_clk) begin
    cycles <= cycles + 1;
    if (cycles == 5000) begin
      err_total++;
      report_and_stop();
    end
  end

  function automatic logic [10:0] pkt_exp(input int c);
    return (c == 7) ? 11'h3ff : 11'(8 << c);
  endfunction

  task automatic report_and_stop;
    $display("comparisons %0d mismatches %0d", comparisons, err_total);
    if (err_total == 0 && comparisons > 0) $display("All tests passed");
    else $display("Some tests failed");
    $finish;
  endtask

  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    s_axi_awaddr <= a;
    s_axi_wdata <= d;
    s_axi_awvalid <= 1'h1;
    s_axi_wvalid <= 1'h1;
    s_axi_bready <= 1'h1;
    do begin
      @(posedge sys_clk);
      if (s_axi_awready) s_axi_awvalid <= 1'h0;
      if (s_axi_wready) s_axi_wvalid <= 1'h0;
    end while (!s_axi_bvalid);
    rsp = s_axi_bresp;
    s_axi_bready <= 1'h0;
    repeat (2) @(posedge sys_clk);
  endtask

  task automatic rd(input logic [7:0] a);
    s_axi_araddr <= a;
    s_axi_arvalid <= 1'h1;
    s_axi_rready <= 1'h1;
    do begin
      @(posedge sys_clk);
      if (s_axi_arready) s_axi_arvalid <= 1'h0;
    end while (!s_axi_rvalid);
    r = s_axi_rdata;
    rsp = s_axi_rresp;
    s_axi_rready <= 1'h0;
    repeat (2) @(posedge sys_clk);
  endtask

  // Device answers after one to four cycles, chosen at random
  task automatic usb(input txn_result_s t);
    res <= t;
    lat <= 4'h1 + 4'($random(seed) & 3);
    go <= 1'h1;
    @(posedge sys_clk);
    go <= 1'h0;
    while (!txn_valid) @(posedge sys_clk);
    repeat (3) @(posedge sys_clk);
  endtask

  initial begin
    repeat (16) @(posedge sys_clk);
    rst_n <= 1'h1;
    @(posedge sys_clk);
    `CHK("max_pkt", 11'h008, max_pkt_bytes)
    for (k = 0; k < 8; k++) begin
      wr(ADDR_PACKET_SIZE, 32'(k) << 28);
      `CHK("max_pkt", pkt_exp(k), max_pkt_bytes)
    end
    e = $random(seed);
    wr(ADDR_PIPE_CONTROL, {16'h0000, 4'h3, e[11:0]});
    `CHK("endpoint", e[11:8], token.target_endpoint)
    `CHK("dev_addr", e[6:0], token.target_device_addr)
    wr(ADDR_EXT_TOKEN, {19'h0_0000, e[20:12], e[3:0]});
    `CHK("payload", {2'h0, e[20:12]}, token.ext_payload)
    `CHK("subtype", e[3:0], token.ext_token_subtype)
    s_axi_wstrb <= 4'h1;
    wr(ADDR_PIPE_CONTROL, 32'h0000_ffff);
    s_axi_wstrb <= 4'hf;
    `CHK("lane_addr", 7'h7f, token.target_device_addr)
    `CHK("lane_ep", e[11:8], token.target_endpoint)
    $display("register fields done");
    wr(ADDR_PIPE_CONFIG, 32'h0000_0001);
    for (k = 0; k < 5; k++) begin
      usb(19'(1) << (15 - k));
      rd(ADDR_PIPE_STATUS);
      `CHK("err_flag", 1'h1, r[4 - k])
      `CHK("tally", 3'(k + 1), r[7:5])
      `CHK("frozen", k >= 2, pipe_frozen)
    end
    wr(ADDR_PIPE_STATUS, 32'h0000_0000);
    wr(ADDR_PIPE_CONFIG, 32'h0000_0005);
    `CHK("thawed", 1'h0, pipe_frozen)
    usb(19'h4_0000);
    rd(ADDR_BANK_STATUS);
    `CHK("flow_fault", 1'h1, r[1])
    rd(ADDR_PIPE_STATUS);
    `CHK("nak_tally", 3'h0, r[7:5])
    usb(19'h0_2800);
    rd(ADDR_PIPE_STATUS);
    `CHK("pid_tgl", 8'h25, r[7:0])
    wr(ADDR_PIPE_CONFIG, 32'h0000_0003);
    `CHK("iso_in", 2'h3, {pipe_is_iso, pipe_is_in})
    wr(ADDR_BANK_STATUS, 32'h0000_0000);
    usb(19'h2_8000);
    rd(ADDR_BANK_STATUS);
    `CHK("iso_crc", 1'h1, r[0])
    `CHK("overrun", 1'h1, r[1])
    $display("error tracking done");
    wr(ADDR_PIPE_CONFIG, 32'h0000_0001);
    wr(ADDR_PACKET_SIZE, 32'h0000_0000);
    e = $random(seed);
    usb({9'h001, 4'h0, e[5:0]});
    usb({9'h001, 4'h0, e[13:8]});
    `CHK("in_total", 14'(e[5:0]) + e[13:8], xfer_size)
    rd(ADDR_PACKET_SIZE);
    `CHK("in_field", 14'(e[5:0]) + e[13:8], r[27:14])
    wr(ADDR_PIPE_CONFIG, 32'h0000_0000);
    `CHK("out_pipe", 2'h0, {pipe_is_iso, pipe_is_in})
    wr(ADDR_PACKET_SIZE, {4'hb, 4'h0, e[19:16], 6'h00, 14'h0000});
    `CHK("zlp", 1'h1, auto_zlp)
    `CHK("out_total", {4'h0, e[19:16], 6'h00}, xfer_size)
    usb({9'h001, 4'h0, e[29:24]});
    `CHK("byte_count", e[29:24], byte_count)
    $display("transfer sizes done");
    rd(8'hfc);
    `CHK("rd_resp", RESP_SLVERR, rsp)
    `CHK("rd_data", 32'h0000_0000, r)
    wr(8'hfc, 32'hffff_ffff);
    `CHK("wr_resp", RESP_SLVERR, rsp)
    $display("unmapped access done");
    report_and_stop();
  end
endmodule
`default_nettype wire
